// ### shared/bcc_pkg.sv
// Purpose: Shared constants and types for the converter config block.
// Assumes: A 25 MHz core clock.
// Notes: Configuration words are 8 bits wide, word 0 is the lowest.
`default_nettype none
package bcc_pkg;
  localparam int CLK_MHZ = 25;
  localparam int DLY_UNIT_US = 100;
  localparam int DLY_UNIT_CYC = DLY_UNIT_US * CLK_MHZ;
  localparam int RAMP_STEP_NS = 2000;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ) / 1000;
  localparam int SYNC_HALF_NS = 160;
  localparam int SYNC_HALF_CYC = (SYNC_HALF_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] A_OPER = 4'h0;
  localparam logic [3:0] A_VOUT = 4'h1;
  localparam logic [3:0] A_ONOFF = 4'h2;
  localparam logic [3:0] A_PINCFG = 4'h3;
  localparam logic [3:0] A_FEAT = 4'h4;
  localparam logic [3:0] A_TON = 4'h5;
  localparam logic [3:0] A_TOFF = 4'h6;
  localparam logic [3:0] A_VOFF = 4'h7;
  localparam logic [3:0] A_STORE = 4'h8;
  localparam logic [3:0] A_NVM_LEFT = 4'h9;
  localparam logic [3:0] A_STATUS = 4'hA;
  localparam logic [3:0] A_VREF = 4'hB;
  localparam logic [3:0] A_IOUT = 4'hC;
  localparam logic [3:0] A_TEMP_DIE = 4'hD;
  localparam logic [3:0] A_TEMP_PT = 4'hE;
  localparam logic [3:0] A_COMP = 4'hF;
  localparam int PIN_STRAP_DIS_BIT = 0;
  localparam int PIN_SYNC_LSB = 1;
  localparam int FEAT_TRACK_BIT = 0;
  localparam int STAT_FAIL_BIT = 7;
  localparam logic [1:0] ONOFF_PIN = 2'h0;
  localparam logic [1:0] ONOFF_CMD = 2'h1;
  localparam logic [1:0] ONOFF_BOTH = 2'h2;
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_IN = 2'h1;
  localparam logic [1:0] SYNC_OUT = 2'h2;
  localparam logic [7:0] FACT_VOUT = 8'h64;
  localparam logic [7:0] FACT_TON = 8'h0A;
  localparam logic [7:0] FACT_TOFF = 8'h0A;
  localparam logic [7:0] FACT_VOFF = 8'h00;
  localparam logic [7:0] FACT_ZERO = 8'h00;
  localparam int NVM_NPARAM = 7;
  localparam int NVM_SAVES = 3;
  localparam logic [7:0] NVM_CAP = 8'(NVM_SAVES * NVM_NPARAM);
  localparam logic [3:0] NVM_W_MARK = 4'h7;
  localparam logic [3:0] NVM_W_LEFT = 4'h8;
  localparam logic [3:0] BOOT_LAST = 4'hA;
  localparam logic [7:0] NVM_MARK = 8'hA5;
  localparam logic signed [8:0] TEMP_MIN = -9'sd40;
  localparam logic signed [8:0] TEMP_MAX = 9'sd150;

  typedef struct packed {
    logic [7:0] voff;
    logic [7:0] toff;
    logic [7:0] ton;
    logic [7:0] feat;
    logic [7:0] pincfg;
    logic [7:0] onoff;
    logic [7:0] vout;
  } bcc_cfg_type;

  localparam bcc_cfg_type FACT_CFG = '{voff: FACT_VOFF, toff: FACT_TOFF,
    ton: FACT_TON, feat: FACT_ZERO, pincfg: FACT_ZERO, onoff: FACT_ZERO,
    vout: FACT_VOUT};

  typedef enum logic [2:0] {
    ST_BOOT, ST_OFF, ST_ON_DLY, ST_RISE, ST_REG, ST_OFF_DLY, ST_FALL
  } bcc_state_type;
endpackage : bcc_pkg
`default_nettype wire

// ### logic/bcc_nvm_mem.sv
// Purpose: Small word store standing in for the non-volatile array.
// Assumes: One write port and one read port on the core clock.
// Notes: The array has no reset so its contents outlive a reset.
`timescale 1ns/100ps
`default_nettype none
module bcc_nvm_mem #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_r
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[raddr];
    end
  end
endmodule : bcc_nvm_mem
`default_nettype wire

// ### logic/bcc_ctrl.sv
// Purpose: Config store, set point and enable sequencing of a buck rail.
// Assumes: Strap, tracking, sense and telemetry codes share clk.
// Notes: Control pin and sync pin are asynchronous and are synchronised.
`timescale 1ns/100ps
`default_nettype none
module bcc_ctrl
  import bcc_pkg::*;
#(
  parameter logic [7:0] OCP_LIMIT = 8'hC8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic ctrl_pin,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe,
  input wire logic [7:0] vout_strap_resistor,
  input wire logic [7:0] compensation_strap_resistor,
  input wire logic [7:0] tracking_voltage_input,
  input wire logic [7:0] vout_sense,
  input wire logic [7:0] iout_sample,
  input wire logic iout_valid,
  input wire logic signed [8:0] die_temp,
  input wire logic signed [8:0] pt_temp,
  output logic [7:0] vref_out,
  output logic drv_en,
  output logic power_good_output,
  output logic ocp_flag,
  output logic sync_pulse
);
  function automatic logic [7:0] cfg_word(input bcc_cfg_type c,
                                          input logic [3:0] i);
    logic [55:0] b;
    b = c;
    return (i < 4'(NVM_NPARAM)) ? b[i*8 +: 8] : 8'h00;
  endfunction : cfg_word

  function automatic logic [7:0] count_diff(input bcc_cfg_type a,
                                            input bcc_cfg_type b);
    logic [7:0] n;
    n = 8'h00;
    for (int k = 0; k < NVM_NPARAM; k++) begin
      if (cfg_word(a, k[3:0]) != cfg_word(b, k[3:0])) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction : count_diff

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    return (a < b) ? a : b;
  endfunction : min8

  function automatic logic [7:0] tclamp(input logic signed [8:0] t);
    logic [8:0] s;
    s = 9'(t - TEMP_MIN);
    if (t < TEMP_MIN) begin
      s = 9'h000;
    end else if (t > TEMP_MAX) begin
      s = 9'(TEMP_MAX - TEMP_MIN);
    end
    return s[7:0];
  endfunction : tclamp

  bcc_state_type st_r, st_nxt;
  bcc_cfg_type cfg_r, cfg_nxt, shadow_r, shadow_nxt, ld_cfg;
  logic [8:0][7:0] ld_r, ld_nxt;
  logic [7:0] left_r, left_nxt, vset_r, vset_nxt, comp_r, comp_nxt;
  logic [7:0] vstrap_r, vstrap_nxt, diff, vref_r, vref_nxt, tgt, floor_v;
  logic [3:0] boot_idx_r, boot_idx_nxt, sidx_r, sidx_nxt;
  logic oper_r, oper_nxt, busy_r, busy_nxt, fail_r, fail_nxt, store_go;
  logic mem_we;
  logic [7:0] mem_wdata, mem_rdata;
  logic ctrl_m_r, ctrl_s_r, sync_m_r, sync_s_r, sync_d_r;
  logic sync_o_r, sync_o_nxt, sync_oe_r, sync_pulse_r;
  logic [2:0] sg_r, sg_nxt;
  logic [1:0] sync_mode;
  logic en_req, trk_en, unit_tick, ramp_tick;
  logic [7:0] cnt_r, cnt_nxt;
  logic [11:0] pre_r, pre_nxt;
  logic [5:0] ramp_r;
  logic drv_r, pg_r;
  logic [9:0] iavg_r, iavg_nxt;
  logic ocp_r, ocp_nxt;
  logic [7:0] tdie_r, tpt_r, rdata_r, rdata_nxt;

  assign trk_en = cfg_r.feat[FEAT_TRACK_BIT];
  assign sync_mode = cfg_r.pincfg[PIN_SYNC_LSB +: 2];
  assign diff = count_diff(cfg_r, shadow_r);
  assign store_go = bus_wr && bus_addr == A_STORE && st_r != ST_BOOT
                    && !busy_r;
  assign ld_cfg = bcc_cfg_type'(ld_r[6:0]);

  bcc_nvm_mem #(.W(8), .AW(4)) u_nvm (
    .clk(clk),
    .arst_n(arst_n),
    .we(mem_we),
    .waddr(sidx_r),
    .wdata(mem_wdata),
    .raddr(boot_idx_r),
    .rdata_r(mem_rdata)
  );

  // Configuration, boot load and store.
  always_comb begin
    cfg_nxt = cfg_r;
    shadow_nxt = shadow_r;
    left_nxt = left_r;
    vset_nxt = vset_r;
    comp_nxt = comp_r;
    vstrap_nxt = vstrap_r;
    oper_nxt = oper_r;
    ld_nxt = ld_r;
    boot_idx_nxt = boot_idx_r;
    busy_nxt = busy_r;
    sidx_nxt = sidx_r;
    fail_nxt = fail_r;
    mem_we = 1'b0;
    mem_wdata = cfg_word(shadow_r, sidx_r);
    if (st_r == ST_BOOT) begin
      if (boot_idx_r == 4'h0) begin
        vstrap_nxt = vout_strap_resistor;
        comp_nxt = compensation_strap_resistor;
      end else if (boot_idx_r != BOOT_LAST) begin
        ld_nxt[boot_idx_r - 4'h1] = mem_rdata;
      end
      boot_idx_nxt = boot_idx_r + 4'h1;
      if (boot_idx_r == BOOT_LAST) begin
        boot_idx_nxt = boot_idx_r;
        // A never written array fails the marker test, so factory values
        // are taken instead of whatever the array happens to hold.
        if (ld_r[NVM_W_MARK] == NVM_MARK) begin
          cfg_nxt = ld_cfg;
          left_nxt = ld_r[NVM_W_LEFT];
        end else begin
          cfg_nxt = FACT_CFG;
          left_nxt = NVM_CAP;
        end
        shadow_nxt = cfg_nxt;
        vset_nxt = cfg_nxt.pincfg[PIN_STRAP_DIS_BIT] ? cfg_nxt.vout
                                                     : vstrap_r;
      end
    end else if (bus_wr) begin
      case (bus_addr)
        A_OPER: oper_nxt = bus_wdata[0];
        A_VOUT: begin
          cfg_nxt.vout = bus_wdata;
          vset_nxt = bus_wdata;
        end
        A_ONOFF: cfg_nxt.onoff = bus_wdata;
        A_PINCFG: cfg_nxt.pincfg = bus_wdata;
        A_FEAT: cfg_nxt.feat = bus_wdata;
        A_TON: cfg_nxt.ton = bus_wdata;
        A_TOFF: cfg_nxt.toff = bus_wdata;
        A_VOFF: cfg_nxt.voff = bus_wdata;
        A_STATUS: if (bus_wdata[STAT_FAIL_BIT]) fail_nxt = 1'b0;
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (store_go) begin
      if (diff > left_r) begin
        fail_nxt = 1'b1;
      end else begin
        busy_nxt = 1'b1;
        sidx_nxt = 4'h0;
        shadow_nxt = cfg_r;
        left_nxt = left_r - diff;
      end
    end
    if (busy_r) begin
      mem_we = 1'b1;
      if (sidx_r == NVM_W_MARK) begin
        mem_wdata = NVM_MARK;
      end else if (sidx_r == NVM_W_LEFT) begin
        mem_wdata = left_r;
      end
      sidx_nxt = sidx_r + 4'h1;
      if (sidx_r == NVM_W_LEFT) begin
        busy_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= FACT_CFG;
      shadow_r <= FACT_CFG;
      ld_r <= '0;
      left_r <= 8'h00;
      vset_r <= 8'h00;
      comp_r <= 8'h00;
      vstrap_r <= 8'h00;
      oper_r <= 1'b0;
      boot_idx_r <= 4'h0;
      busy_r <= 1'b0;
      sidx_r <= 4'h0;
      fail_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      shadow_r <= shadow_nxt;
      ld_r <= ld_nxt;
      left_r <= left_nxt;
      vset_r <= vset_nxt;
      comp_r <= comp_nxt;
      vstrap_r <= vstrap_nxt;
      oper_r <= oper_nxt;
      boot_idx_r <= boot_idx_nxt;
      busy_r <= busy_nxt;
      sidx_r <= sidx_nxt;
      fail_r <= fail_nxt;
    end
  end

  // Sequencer. Delay units are counted by a shared prescaler that restarts
  // as each delay begins, so a delay runs its full nominal length.
  always_comb begin
    case (cfg_r.onoff[1:0])
      ONOFF_CMD: en_req = oper_r;
      ONOFF_BOTH: en_req = oper_r && ctrl_s_r;
      default: en_req = ctrl_s_r;
    endcase
    tgt = trk_en ? min8(vset_r, tracking_voltage_input) : vset_r;
    floor_v = trk_en ? 8'h00 : cfg_r.voff;
    unit_tick = pre_r == 12'(DLY_UNIT_CYC - 1);
    ramp_tick = ramp_r == 6'(RAMP_STEP_CYC - 1);
    pre_nxt = unit_tick ? 12'h000 : pre_r + 12'h001;
    st_nxt = st_r;
    vref_nxt = vref_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_BOOT: if (boot_idx_r == BOOT_LAST) st_nxt = ST_OFF;
      ST_OFF: begin
        vref_nxt = 8'h00;
        if (en_req) begin
          st_nxt = ST_ON_DLY;
          cnt_nxt = cfg_r.ton;
          pre_nxt = 12'h000;
        end
      end
      ST_ON_DLY: begin
        if (!en_req) begin
          st_nxt = ST_OFF;
        end else if (cnt_r == 8'h00) begin
          st_nxt = ST_RISE;
          vref_nxt = min8(vout_sense, tgt);
        end else if (unit_tick) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_RISE, ST_REG: begin
        if (!en_req) begin
          st_nxt = ST_OFF_DLY;
          cnt_nxt = cfg_r.toff;
          pre_nxt = 12'h000;
        end else begin
          if (vref_r > tgt) begin
            vref_nxt = tgt;
          end else if (ramp_tick && vref_r < tgt) begin
            vref_nxt = vref_r + 8'h01;
          end
          if (st_r == ST_RISE && vref_nxt == tgt && tgt != 8'h00) begin
            st_nxt = ST_REG;
          end
        end
      end
      ST_OFF_DLY: begin
        if (trk_en && vref_r > tracking_voltage_input) begin
          vref_nxt = tracking_voltage_input;
        end
        if (en_req) begin
          st_nxt = ST_RISE;
        end else if (cnt_r == 8'h00) begin
          st_nxt = ST_FALL;
        end else if (unit_tick) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_FALL: begin
        if (en_req) begin
          st_nxt = ST_RISE;
        end else if (vref_r <= floor_v) begin
          st_nxt = ST_OFF;
        end else if (trk_en && vref_r > tracking_voltage_input) begin
          vref_nxt = tracking_voltage_input;
        end else if (ramp_tick) begin
          vref_nxt = vref_r - 8'h01;
        end
      end
      default: st_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_BOOT;
      vref_r <= 8'h00;
      cnt_r <= 8'h00;
      pre_r <= 12'h000;
      ramp_r <= 6'h00;
      drv_r <= 1'b0;
      pg_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      vref_r <= vref_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      ramp_r <= ramp_tick ? 6'h00 : ramp_r + 6'h01;
      drv_r <= st_nxt inside {ST_RISE, ST_REG, ST_OFF_DLY, ST_FALL};
      pg_r <= st_nxt == ST_REG;
    end
  end

  // Pins, telemetry and register reads.
  always_comb begin
    sg_nxt = (sg_r == 3'(SYNC_HALF_CYC - 1)) ? 3'h0 : sg_r + 3'h1;
    sync_o_nxt = (sync_mode != SYNC_OUT) ? 1'b0
               : (sg_r == 3'h0) ? !sync_o_r : sync_o_r;
    iavg_nxt = iout_valid ? iavg_r + 10'(iout_sample) - 10'(iavg_r[9:2])
                          : iavg_r;
    ocp_nxt = iout_valid ? (iout_sample > OCP_LIMIT) : ocp_r;
    rdata_nxt = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        A_OPER: rdata_nxt = {7'h00, oper_r};
        A_VOUT: rdata_nxt = vset_r;
        A_ONOFF: rdata_nxt = cfg_r.onoff;
        A_PINCFG: rdata_nxt = cfg_r.pincfg;
        A_FEAT: rdata_nxt = cfg_r.feat;
        A_TON: rdata_nxt = cfg_r.ton;
        A_TOFF: rdata_nxt = cfg_r.toff;
        A_VOFF: rdata_nxt = cfg_r.voff;
        A_NVM_LEFT: rdata_nxt = left_r;
        A_STATUS: rdata_nxt = {fail_r, busy_r, ocp_r, pg_r, drv_r, st_r};
        A_VREF: rdata_nxt = vref_r;
        A_IOUT: rdata_nxt = iavg_r[9:2];
        A_TEMP_DIE: rdata_nxt = tdie_r;
        A_TEMP_PT: rdata_nxt = tpt_r;
        A_COMP: rdata_nxt = comp_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_m_r <= 1'b0;
      ctrl_s_r <= 1'b0;
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      sync_pulse_r <= 1'b0;
      sync_o_r <= 1'b0;
      sync_oe_r <= 1'b0;
      sg_r <= 3'h0;
      iavg_r <= 10'h000;
      ocp_r <= 1'b0;
      tdie_r <= 8'h00;
      tpt_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      ctrl_m_r <= ctrl_pin;
      ctrl_s_r <= ctrl_m_r;
      sync_m_r <= sync_i;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      sync_pulse_r <= sync_mode == SYNC_IN && sync_s_r && !sync_d_r;
      sync_o_r <= sync_o_nxt;
      sync_oe_r <= sync_mode == SYNC_OUT;
      sg_r <= sg_nxt;
      iavg_r <= iavg_nxt;
      ocp_r <= ocp_nxt;
      tdie_r <= tclamp(die_temp);
      tpt_r <= tclamp(pt_temp);
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;
  assign sync_o = sync_o_r;
  assign sync_oe = sync_oe_r;
  assign vref_out = vref_r;
  assign drv_en = drv_r;
  assign power_good_output = pg_r;
  assign ocp_flag = ocp_r;
  assign sync_pulse = sync_pulse_r;

  chk_release_hiz: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == ST_FALL && st_nxt == ST_OFF) |=> !drv_en ##1 !drv_en)
    else $error("Drivers not released after ramp down.");
  chk_pgood_slew: assert property (@(posedge clk) disable iff (!arst_n)
    (bus_wr && bus_addr == A_VOUT && st_r == ST_REG && en_req)
    |=> power_good_output)
    else $error("Power good dropped during commanded change.");
  chk_track_boot: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == ST_BOOT) |-> !trk_en)
    else $error("Tracking active before boot completed.");
  chk_track_lower: assert property (@(posedge clk) disable iff (!arst_n)
    (trk_en && st_r == ST_REG && en_req)
    |=> vref_r <= $past(tracking_voltage_input))
    else $error("Set point above tracking input.");
  chk_pin_only: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == ST_OFF && cfg_r.onoff[1:0] == ONOFF_PIN && !ctrl_s_r)
    |=> st_r == ST_OFF)
    else $error("Command enabled output in pin mode.");
  chk_prebias_start: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r == ST_ON_DLY && st_nxt == ST_RISE)
    |=> vref_r == min8($past(vout_sense), $past(tgt)) && drv_en)
    else $error("Ramp did not start from pre-bias level.");
  chk_store_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    (store_go && diff > left_r) |=> fail_r && !busy_r && $stable(left_r))
    else $error("Store accepted beyond remaining space.");
  chk_strap_fixed: assert property (@(posedge clk) disable iff (!arst_n)
    (st_r != ST_BOOT) |=> $stable(comp_r) && $stable(vstrap_r))
    else $error("Strap value changed after boot.");
  chk_ocp_raw: assert property (@(posedge clk) disable iff (!arst_n)
    (iout_valid && iout_sample > OCP_LIMIT) |=> ocp_flag)
    else $error("Overcurrent not flagged on raw sample.");
  chk_sync_dir: assert property (@(posedge clk) disable iff (!arst_n)
    (sync_mode != SYNC_OUT) |=> !sync_oe && !sync_o)
    else $error("Sync pin driven while not an output.");
endmodule : bcc_ctrl
`default_nettype wire

// ### verification/bcc_far_side.sv
// Purpose: Far side of the rail: enable pin, sync source, current samples.
// Assumes: The bench sets the wanted levels through this model's inputs.
// Notes: The sync clock stands still low while the link is off.
`timescale 1ns/100ps
`default_nettype none
module bcc_far_side (
  input wire logic clk,
  input wire logic want_on,
  input wire logic link_on,
  input wire logic [7:0] amps,
  output logic ctrl_pin,
  output logic sync_i,
  output logic [7:0] iout_sample,
  output logic iout_valid
);
  logic [2:0] div = 3'h0;
  assign ctrl_pin = want_on;
  initial begin
    sync_i = 1'b0;
    #7;
    forever begin
      #160;
      sync_i = link_on ? ~sync_i : 1'b0;
    end
  end
  always @(posedge clk) begin
    div <= div + 3'h1;
    iout_valid <= (div == 3'h0);
    iout_sample <= amps;
  end
endmodule : bcc_far_side
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for the converter config block.
// Assumes: Reads are checked through a queue one cycle after the strobe.
// Notes: Store space is checked word by word, down to a refused store.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import bcc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00, trk = 8'h00, vs = 8'h00, amps = 8'h00;
  logic [7:0] comp = 8'h00, strap = 8'h30, bus_rdata, vref_out, d, last;
  logic want_on = 1'b0, link_on = 1'b0, rd_chk = 1'b0, rd_chk_d = 1'b0;
  logic ctrl_pin, sync_i, sync_o, sync_oe, drv_en, power_good_output;
  logic ocp_flag, sync_pulse, iout_valid;
  logic [7:0] iout_sample;
  logic signed [8:0] die = 9'sd0, pt = 9'sd0;
  logic [1:0] md [4] = '{ONOFF_PIN, ONOFF_CMD, ONOFF_BOTH, ONOFF_BOTH};
  logic [7:0] expq [$];
  int mismatches = 0, samples_checked = 0, cyc = 0, seed = 28, n, i;

  always #20 clk = ~clk;

  bcc_far_side u_far (.clk(clk), .want_on(want_on), .link_on(link_on),
    .amps(amps), .ctrl_pin(ctrl_pin), .sync_i(sync_i),
    .iout_sample(iout_sample), .iout_valid(iout_valid));

  bcc_ctrl u_dut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .ctrl_pin(ctrl_pin), .sync_i(sync_i),
    .sync_o(sync_o), .sync_oe(sync_oe), .vout_strap_resistor(strap),
    .compensation_strap_resistor(comp), .tracking_voltage_input(trk),
    .vout_sense(vs), .iout_sample(iout_sample), .iout_valid(iout_valid),
    .die_temp(die), .pt_temp(pt), .vref_out(vref_out), .drv_en(drv_en),
    .power_good_output(power_good_output), .ocp_flag(ocp_flag),
    .sync_pulse(sync_pulse));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample it there.
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic c);
    if (c) expq.push_back(e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    rd_chk <= c;
    @(posedge clk);
    bus_rd <= 1'b0;
    rd_chk <= 1'b0;
    #1 d = bus_rdata;
    @(posedge clk);
  endtask : rd

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : do_reset

  task automatic wait_pg();
    n = 0;
    while (power_good_output !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask : wait_pg

  task automatic wait_off();
    n = 0;
    while (drv_en !== 1'b0 && n < 9000) begin
      last = vref_out;
      @(posedge clk);
      n++;
    end
    if (n >= 9000) mismatches++;
  endtask : wait_off

  always @(posedge clk) begin
    rd_chk_d <= bus_rd & rd_chk;
    if (rd_chk_d) check(bus_rdata, expq.pop_front(), "read data");
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    comp <= 8'($random(seed));
    vs <= 8'h04 + (8'($random(seed)) & 8'h0F);
    do_reset();
    rd(A_TON, FACT_TON, 1'b1); // factory delay
    rd(A_TOFF, FACT_TOFF, 1'b1); // factory delay
    rd(A_ONOFF, 8'h00, 1'b1); // pin default
    rd(A_PINCFG, 8'h00, 1'b1); // sync off
    rd(A_FEAT, 8'h00, 1'b1); // tracking off
    wr(A_COMP, ~comp);
    rd(A_COMP, comp, 1'b1); // strap fixed
    check(8'(sync_oe), 8'h00, "sync drive"); // pin idle
    $display("test defaults done");
    for (i = 0; i < 4; i++) begin
      want_on <= 1'b0;
      do_reset();
      wr(A_ONOFF, {6'h00, md[i]});
      want_on <= (i == 3);
      wr(A_OPER, 8'h01);
      repeat (6) @(posedge clk);
      rd(A_STATUS, 8'h00, 1'b0);
      check(d & 8'h07, (i % 2) ? 8'h02 : 8'h01, "state"); // source
    end
    $display("test enable sources done");
    want_on <= 1'b0;
    do_reset();
    wr(A_TON, 8'h01);
    wr(A_TOFF, 8'h01);
    wr(A_VOUT, 8'h20);
    wr(A_VOFF, 8'h08);
    want_on <= 1'b1;
    n = 0;
    while (drv_en !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check(8'(n >= 2500), 8'h01, "on delay"); // delay first
    check(8'(vref_out >= vs && vref_out <= vs + 8'h01), 8'h01, "start");
    wait_pg();
    check(vref_out, 8'h20, "ramp end"); // ramp completes
    wr(A_VOUT, 8'h28);
    n = 0;
    repeat (600) begin
      @(posedge clk);
      if (power_good_output !== 1'b1) n++;
    end
    check(8'(n), 8'h00, "good drops"); // good held
    check(vref_out, 8'h28, "new set point"); // live change
    want_on <= 1'b0;
    wait_off();
    check(last, 8'h08, "off level"); // ramp to level
    check(8'(n >= 2500), 8'h01, "off delay"); // delay first
    $display("test ramps done");
    wr(A_TON, 8'h03);
    wr(A_STORE, 8'h01);
    repeat (12) @(posedge clk);
    rd(A_NVM_LEFT, NVM_CAP - 8'd4, 1'b1); // four words charged
    wr(A_TOFF, 8'h05);
    do_reset();
    rd(A_TON, 8'h03, 1'b1); // stored value
    rd(A_TOFF, 8'h01, 1'b1); // edit lost
    $display("test store done");
    wr(A_FEAT, 8'h01);
    wr(A_VOUT, 8'h20);
    want_on <= 1'b1;
    repeat (9000) @(posedge clk);
    check(8'(power_good_output), 8'h00, "track hold"); // low input
    trk <= 8'h10;
    wait_pg();
    check(vref_out, 8'h10, "track point"); // lower wins
    want_on <= 1'b0;
    wait_off();
    check(last, 8'h00, "track off"); // track overrides
    $display("test tracking done");
    wr(A_PINCFG, 8'h02);
    link_on <= 1'b1;
    n = 0;
    repeat (64) begin
      @(posedge clk);
      if (sync_pulse === 1'b1) n++;
    end
    check(8'(n >= 7 && n <= 9), 8'h01, "sync pulses"); // input mode
    link_on <= 1'b0;
    wr(A_PINCFG, 8'h04);
    repeat (4) @(posedge clk);
    check(8'(sync_oe), 8'h01, "sync drive"); // output mode
    n = 0;
    repeat (64) begin
      @(posedge clk);
      if (sync_o === 1'b1) n++;
    end
    check(8'(n), 8'd32, "sync out"); // half high
    amps <= 8'hD0;
    repeat (20) @(posedge clk);
    check(8'(ocp_flag), 8'h01, "overcurrent"); // raw path
    amps <= 8'h10;
    repeat (20) @(posedge clk);
    check(8'(ocp_flag), 8'h00, "overcurrent"); // raw path
    repeat (400) @(posedge clk);
    rd(A_IOUT, 8'h10, 1'b1); // averaged report
    die <= -9'sd50;
    pt <= 9'sd20;
    repeat (4) @(posedge clk);
    rd(A_TEMP_DIE, 8'h00, 1'b1); // low clamp
    rd(A_TEMP_PT, 8'h3C, 1'b1); // offset reading
    $display("test misc done");
    for (i = 0; i < 4; i++) begin
      wr(A_TON, 8'h10 + 8'(i));
      wr(A_TOFF, 8'h10 + 8'(i));
      wr(A_VOFF, 8'h10 + 8'(i));
      wr(A_VOUT, 8'h10 + 8'(i));
      wr(A_STORE, 8'h01);
      repeat (12) @(posedge clk);
    end
    rd(A_NVM_LEFT, NVM_CAP - 8'd18, 1'b1); // refused store keeps space
    rd(A_STATUS, 8'h00, 1'b0);
    check(d & 8'hC0, 8'h80, "store refused"); // space too short
    $display("test store limit done");
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
